// File: logic/byte_lane_data_steering.sv
// byte-lane select generation and data steering for an 8/16/32-bit memory bus
//
// What this block does
// - 32-bit word reads select all lanes straight
// - 32-bit half and byte lane patterns per offset
// - 8-bit word write: four bytes, top first
// - 8-bit half is two bytes; byte is one
// - 16-bit word write: two halves, upper first
// - 16-bit half both lanes; byte one lane
// - write data steered onto external bus lanes
// - same mapping for static and dynamic paths
// - read lane selects follow read-select bit
// - selects active low; writes assert addressed lanes
module byte_lane_data_steering (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // system side
  input  wire logic                     req_valid,
  input  wire steer_pkg::sys_req_t      req,
  output logic                          req_ready,
  output logic                          done,
  output logic [31:0]                   rdata,
  // bank configuration, sampled when an access is taken
  input  wire steer_pkg::ext_width_t    ext_width,
  input  wire logic                     read_lane_select_bit,
  input  wire logic                     path_dynamic,
  // external transfer engine
  output logic                          ext_strobe,
  output logic                          ext_write,
  output logic                          ext_path_dynamic,
  output logic [1:0]                    ext_address_out,
  output logic [3:0]                    byte_lane_select_n,
  output logic [31:0]                   ext_data_bus,
  input  wire logic                     ext_ack,
  input  wire logic [31:0]              ext_rdata
);

  steer_pkg::steer_regs_t state_reg;
  steer_pkg::steer_regs_t state_next;

  logic [1:0]  dec_last;
  logic [1:0]  dec_addr;
  logic [3:0]  dec_lanes_n;
  logic [31:0] dec_wdata;
  logic [31:0] dec_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // decode always works on the captured access, so it is stable per beat
  lane_beat_decode u_decode (
    .width     (state_reg.width),
    .size      (state_reg.size),
    .addr      (state_reg.addr),
    .beat      (state_reg.beat),
    .wdata     (state_reg.wdata),
    .ext_rdata (ext_rdata),
    .rdata_in  (state_reg.rdata),
    .last_beat (dec_last),
    .beat_addr (dec_addr),
    .lanes_n   (dec_lanes_n),
    .wdata_out (dec_wdata),
    .rdata_out (dec_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    case (state_reg.state)
      steer_pkg::ST_IDLE: begin
        if (req_valid) begin
          state_next.state    = steer_pkg::ST_LOAD;
          state_next.ready    = 1'b0;
          state_next.beat     = steer_pkg::BEAT_FIRST;
          state_next.write    = req.write;
          state_next.size     = req.size;
          state_next.addr     = req.addr;
          state_next.wdata    = req.wdata;
          state_next.width    = ext_width;
          state_next.lane_rd  = read_lane_select_bit;
          // only tagged through; the steering tables do not depend on it
          state_next.path_dyn = path_dynamic;
        end
      end
      steer_pkg::ST_LOAD: begin
        state_next.state     = steer_pkg::ST_ISSUE;
        state_next.last      = dec_last;
        state_next.ext_addr  = dec_addr;
        state_next.ext_write = state_reg.write;
        state_next.strobe    = 1'b1;
        if (state_reg.write) begin
          state_next.lanes_n  = dec_lanes_n;
          state_next.ext_data = dec_wdata;
        end else begin
          // byte-wide banks wire the selects to write enables
          state_next.lanes_n  = state_reg.lane_rd ? dec_lanes_n
                                                  : steer_pkg::LANES_NONE_N;
          state_next.ext_data = steer_pkg::DATA_ZERO;
        end
      end
      steer_pkg::ST_ISSUE: begin
        if (ext_ack) begin
          state_next.strobe  = 1'b0;
          state_next.lanes_n = steer_pkg::LANES_NONE_N;
          if (!state_reg.write) begin
            state_next.rdata = dec_rdata;
          end
          if (state_reg.beat == state_reg.last) begin
            state_next.state = steer_pkg::ST_IDLE;
            state_next.ready = 1'b1;
            state_next.done  = 1'b1;
          end else begin
            state_next.state = steer_pkg::ST_LOAD;
            state_next.beat  = state_reg.beat + steer_pkg::BEAT_STEP;
          end
        end
      end
      default: begin
        state_next.state = steer_pkg::ST_IDLE;
        state_next.ready = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg           <= '0;
      state_reg.state     <= steer_pkg::ST_IDLE;
      state_reg.lanes_n   <= steer_pkg::LANES_NONE_N;
      state_reg.ready     <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign req_ready          = state_reg.ready;
  assign done               = state_reg.done;
  assign rdata              = state_reg.rdata;
  assign ext_strobe         = state_reg.strobe;
  assign ext_write          = state_reg.ext_write;
  assign ext_path_dynamic   = state_reg.path_dyn;
  assign ext_address_out    = state_reg.ext_addr;
  assign byte_lane_select_n = state_reg.lanes_n;
  assign ext_data_bus       = state_reg.ext_data;

endmodule : byte_lane_data_steering

// File: logic/steer_pkg.sv
// shared types and constants for the byte-lane steering block
package steer_pkg;

  localparam int unsigned DATA_W = 32;

  typedef enum logic [2:0] {
    SIZE_BYTE = 3'h0,
    SIZE_HALF = 3'h1,
    SIZE_WORD = 3'h2
  } xfer_size_t;

  typedef enum logic [1:0] {
    EXT_W8  = 2'h0,
    EXT_W16 = 2'h1,
    EXT_W32 = 2'h2
  } ext_width_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_LOAD  = 2'h1,
    ST_ISSUE = 2'h2
  } steer_state_t;

  // active-low lane patterns, bit n drives lane n
  localparam logic [3:0] LANES_NONE_N      = 4'hf;
  localparam logic [3:0] LANES_ALL_N       = 4'h0;
  localparam logic [3:0] LANES_LOW_HALF_N  = 4'hc;
  localparam logic [3:0] LANES_HIGH_HALF_N = 4'h3;
  localparam logic [3:0] LANE0_N           = 4'he;
  localparam logic [3:0] LANE1_N           = 4'hd;
  localparam logic [3:0] LANE_ONE_HOT      = 4'h1;

  // index of the last beat of a split
  localparam logic [1:0] LAST_OF_ONE  = 2'h0;
  localparam logic [1:0] LAST_OF_TWO  = 2'h1;
  localparam logic [1:0] LAST_OF_FOUR = 2'h3;
  localparam logic [1:0] ADDR_TOP     = 2'h3;
  localparam logic [1:0] ADDR_ZERO    = 2'h0;
  localparam logic [1:0] BEAT_FIRST   = 2'h0;
  localparam logic [1:0] BEAT_STEP    = 2'h1;

  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0;

  // one access from the system side
  typedef struct packed {
    logic               write;
    xfer_size_t         size;
    logic [1:0]         addr;
    logic [DATA_W-1:0]  wdata;
  } sys_req_t;

  // complete state of the steering engine
  typedef struct packed {
    steer_state_t       state;
    logic [1:0]         beat;
    logic [1:0]         last;
    logic               write;
    xfer_size_t         size;
    logic [1:0]         addr;
    ext_width_t         width;
    logic               lane_rd;
    logic               path_dyn;
    logic [DATA_W-1:0]  wdata;
    logic [DATA_W-1:0]  rdata;
    logic [1:0]         ext_addr;
    logic [3:0]         lanes_n;
    logic [DATA_W-1:0]  ext_data;
    logic               ext_write;
    logic               strobe;
    logic               ready;
    logic               done;
  } steer_regs_t;

endpackage : steer_pkg

// File: logic/lane_beat_decode.sv
// per-beat lane, address and data steering decode (combinational)
module lane_beat_decode (
  // access being split
  input  wire steer_pkg::ext_width_t  width,
  input  wire steer_pkg::xfer_size_t  size,
  input  wire logic [1:0]             addr,
  input  wire logic [1:0]             beat,
  // data paths
  input  wire logic [31:0]            wdata,
  input  wire logic [31:0]            ext_rdata,
  input  wire logic [31:0]            rdata_in,
  // decoded beat
  output logic [1:0]                  last_beat,
  output logic [1:0]                  beat_addr,
  output logic [3:0]                  lanes_n,
  output logic [31:0]                 wdata_out,
  output logic [31:0]                 rdata_out
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] last_index(steer_pkg::ext_width_t w,
                                            steer_pkg::xfer_size_t s);
    logic [1:0] r;
    r = steer_pkg::LAST_OF_ONE;
    if (w == steer_pkg::EXT_W8 && s == steer_pkg::SIZE_WORD) begin
      r = steer_pkg::LAST_OF_FOUR;
    end else if (w == steer_pkg::EXT_W8 && s == steer_pkg::SIZE_HALF) begin
      r = steer_pkg::LAST_OF_TWO;
    end else if (w == steer_pkg::EXT_W16 && s == steer_pkg::SIZE_WORD) begin
      r = steer_pkg::LAST_OF_TWO;
    end
    return r;
  endfunction : last_index

  // upper bytes go out first in every split
  function automatic logic [1:0] beat_address(steer_pkg::ext_width_t w,
                                              steer_pkg::xfer_size_t s,
                                              logic [1:0] a, logic [1:0] b);
    logic [1:0] r;
    r = steer_pkg::ADDR_ZERO;
    case (w)
      steer_pkg::EXT_W8: begin
        if (s == steer_pkg::SIZE_WORD) r = steer_pkg::ADDR_TOP - b;
        else if (s == steer_pkg::SIZE_HALF) r = {a[1], ~b[0]};
        else r = a;
      end
      steer_pkg::EXT_W16: begin
        if (s == steer_pkg::SIZE_WORD) r = {1'b0, ~b[0]};
        else r = {1'b0, a[1]};
      end
      default: r = steer_pkg::ADDR_ZERO;
    endcase
    return r;
  endfunction : beat_address

  function automatic logic [3:0] lane_pattern(steer_pkg::ext_width_t w,
                                              steer_pkg::xfer_size_t s,
                                              logic [1:0] a);
    logic [3:0] r;
    r = steer_pkg::LANES_NONE_N;
    case (w)
      steer_pkg::EXT_W8: r = steer_pkg::LANE0_N;
      steer_pkg::EXT_W16: begin
        if (s == steer_pkg::SIZE_BYTE) begin
          r = a[0] ? steer_pkg::LANE1_N : steer_pkg::LANE0_N;
        end else begin
          r = steer_pkg::LANES_LOW_HALF_N;
        end
      end
      default: begin
        if (s == steer_pkg::SIZE_BYTE) begin
          r = ~(steer_pkg::LANE_ONE_HOT << a);
        end else if (s == steer_pkg::SIZE_HALF) begin
          r = a[1] ? steer_pkg::LANES_HIGH_HALF_N
                   : steer_pkg::LANES_LOW_HALF_N;
        end else begin
          r = steer_pkg::LANES_ALL_N;
        end
      end
    endcase
    return r;
  endfunction : lane_pattern

  ////////////////////////////////////////////////////////////////////////////
  // lanes above the bus width are driven zero rather than left floating;
  // within the bus width the selects mark which lanes the memory takes
  always_comb begin
    last_beat = last_index(width, size);
    beat_addr = beat_address(width, size, addr, beat);
    lanes_n   = lane_pattern(width, size, addr);
    wdata_out = steer_pkg::DATA_ZERO;
    rdata_out = rdata_in;
    case (width)
      steer_pkg::EXT_W8: begin
        wdata_out[7:0] = wdata[{beat_addr, 3'h0} +: 8];
        rdata_out[{beat_addr, 3'h0} +: 8] = ext_rdata[7:0];
      end
      steer_pkg::EXT_W16: begin
        wdata_out[15:0] = wdata[{beat_addr[0], 4'h0} +: 16];
        rdata_out[{beat_addr[0], 4'h0} +: 16] = ext_rdata[15:0];
      end
      default: begin
        wdata_out = wdata;
        rdata_out = ext_rdata;
      end
    endcase
  end

endmodule : lane_beat_decode

// File: verification/steer_monitor.sv
// port assertions for the byte-lane steering block
module steer_monitor (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // system side
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        done,
  // external side
  input wire logic        ext_strobe,
  input wire logic        ext_write,
  input wire logic        ext_ack,
  input wire logic [1:0]  ext_address_out,
  input wire logic [3:0]  byte_lane_select_n,
  input wire logic [31:0] ext_data_bus
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  sequence beat_end;
    ext_strobe && ext_ack;
  endsequence
  sequence beat_gap;
    !ext_strobe && byte_lane_select_n == 4'hf;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_idle_lanes_off: assert property (!ext_strobe |-> byte_lane_select_n == 4'hf)
    else $error("lane select active outside a beat");
  a_beat_closes: assert property (beat_end |=> beat_gap)
    else $error("beat not closed after ack");
  a_beat_held: assert property (ext_strobe && !ext_ack |=> ext_strobe &&
    $stable(ext_address_out) && $stable(byte_lane_select_n) && $stable(ext_data_bus))
    else $error("beat changed before ack");
  a_read_bus_quiet: assert property (ext_strobe && !ext_write |-> ext_data_bus == 32'h0)
    else $error("data driven on a read beat");
  a_write_lanes_on: assert property (ext_strobe && ext_write |-> byte_lane_select_n != 4'hf)
    else $error("write beat without lane select");
  a_take_busy: assert property (req_valid && req_ready |=> !req_ready && !done)
    else $error("still ready after take");
  a_done_last_beat: assert property (done |-> req_ready && $past(ext_ack) && $past(ext_strobe))
    else $error("done without a closing beat");
  // bound holds for the slowest far side the bench uses
  a_access_bounded: assert property (req_valid && req_ready |-> ##[3:60] done)
    else $error("access never finished");
endmodule : steer_monitor

bind byte_lane_data_steering steer_monitor u_mon (.mclk, .rst, .req_valid, .req_ready, .done,
  .ext_strobe, .ext_write, .ext_ack, .ext_address_out, .byte_lane_select_n, .ext_data_bus);

// File: verification/ext_mem_model.sv
// far-side memory model: acks each beat after a set wait, returns read data
module ext_mem_model (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // beat from the block
  input  wire logic                  ext_strobe,
  input  wire logic [1:0]            ext_address_out,
  input  wire steer_pkg::ext_width_t width,
  input  wire logic [1:0]            lat,
  // answer
  output logic                       ext_ack,
  output logic [31:0]                ext_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] IMG = 32'h8c4ae613;
  logic [1:0] cnt;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 2'h0;
      ext_ack <= 1'b0;
      ext_rdata <= 32'h0;
    end else if (ext_strobe && !ext_ack && cnt == lat) begin
      cnt <= 2'h0;
      ext_ack <= 1'b1;
      ext_rdata <= IMG >> (8 * (1 << int'(width)) * ext_address_out);
    end else begin
      cnt <= (ext_strobe && !ext_ack) ? cnt + 2'h1 : 2'h0;
      ext_ack <= 1'b0;
      // bus released: flip it so a stale value is never read as good
      ext_rdata <= ~ext_rdata;
    end
  end
endmodule : ext_mem_model

// File: verification/byte_lane_data_steering_test.sv
// self-checking bench for the byte-lane steering block
module byte_lane_data_steering_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic       w;
    logic [2:0] s;
    logic [1:0] a;
    logic [1:0] x;
    logic [2:0] n;
    logic [1:0] f;
    logic [3:0] l;
  } row_t;
  localparam logic [31:0] WD  = 32'hd5c4b3a2;
  localparam logic [31:0] IMG = 32'h8c4ae613;
  // write, size, addr, width, beats, first address, lanes
  localparam row_t ROWS [16] = '{
    '{1, 2, 0, 0, 4, 3, 4'he}, '{1, 1, 2, 0, 2, 3, 4'he}, '{1, 1, 1, 0, 2, 1, 4'he},
    '{1, 0, 2, 0, 1, 2, 4'he}, '{0, 2, 0, 0, 4, 3, 4'he}, '{1, 2, 0, 1, 2, 1, 4'hc},
    '{1, 1, 2, 1, 1, 1, 4'hc}, '{1, 0, 3, 1, 1, 1, 4'hd}, '{1, 0, 0, 1, 1, 0, 4'he},
    '{0, 1, 0, 1, 1, 0, 4'hc}, '{1, 2, 0, 2, 1, 0, 4'h0}, '{0, 1, 2, 2, 1, 0, 4'h3},
    '{0, 0, 1, 2, 1, 0, 4'hd}, '{0, 0, 3, 2, 1, 0, 4'h7}, '{1, 0, 2, 2, 1, 0, 4'hb},
    '{0, 2, 0, 2, 1, 0, 4'h0}};
  logic                  mclk, rst, req_valid, req_ready, done, rsel, pdyn;
  logic                  ext_strobe, ext_write, ext_pdyn, ext_ack;
  logic [1:0]            ext_addr, lat;
  logic [3:0]            lanes_n;
  logic [31:0]           rdata, ext_data, ext_rdata;
  steer_pkg::sys_req_t   req;
  steer_pkg::ext_width_t width;
  int                    errors, checked, beats;
  logic [1:0]            b_addr [4];
  logic [3:0]            b_lanes [4];
  logic [31:0]           b_data [4];
  logic                  b_dyn [4];
  logic                  b_wr [4];

  ////////////////////////////////////////////////////////////////////////////////
  byte_lane_data_steering u_dut (.mclk, .rst, .req_valid, .req, .req_ready, .done, .rdata,
    .ext_width(width), .read_lane_select_bit(rsel), .path_dynamic(pdyn), .ext_strobe,
    .ext_write, .ext_path_dynamic(ext_pdyn), .ext_address_out(ext_addr),
    .byte_lane_select_n(lanes_n), .ext_data_bus(ext_data), .ext_ack, .ext_rdata);
  ext_mem_model u_mem (.mclk, .rst, .ext_strobe, .ext_address_out(ext_addr), .width, .lat,
    .ext_ack, .ext_rdata);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (ext_strobe === 1'b1 && ext_ack === 1'b1 && beats < 4) begin
      b_addr[beats] = ext_addr;
      b_lanes[beats] = lanes_n;
      b_data[beats] = ext_data;
      b_dyn[beats] = ext_pdyn;
      b_wr[beats] = ext_write;
    end
    if (ext_strobe === 1'b1 && ext_ack === 1'b1) beats++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_n(input int got, input int exp);
    checked++;
    if (got != exp) begin
      errors++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : cmp_n
  // lanes inside the bus width carry the steered word; lanes above it stay zero
  function automatic logic [31:0] bmask(input logic [1:0] x);
    bmask = x == 2'h0 ? 32'hff : x == 2'h1 ? 32'hffff : 32'hffffffff;
  endfunction : bmask
  task automatic run(input row_t r);
    int          k;
    logic [1:0]  ea;
    logic [31:0] am;
    k = 0;
    beats = 0;
    req = '{r.w, steer_pkg::xfer_size_t'(r.s), r.a, WD};
    width = steer_pkg::ext_width_t'(r.x);
    req_valid = 1'b1;
    @(posedge mclk);
    #1 req_valid = 1'b0;
    while (done !== 1'b1 && k < 100) begin
      @(posedge mclk);
      #1 k++;
    end
    cmp(done, 1'b1);
    cmp_n(beats, r.n);
    for (int i = 0; i < beats && i < 4; i++) begin
      ea = r.f - 2'(i);
      cmp(ea, b_addr[i]);
      cmp(b_lanes[i], (r.w | rsel) ? r.l : 4'hf);
      cmp(b_data[i], r.w ? (WD >> (8 * (1 << r.x) * ea)) & bmask(r.x) : 32'h0);
      cmp(b_wr[i], r.w);
      cmp(b_dyn[i], pdyn);
    end
    am = r.s == 3'h0 ? 32'hff << (8 * r.a) : r.s == 3'h1 ? 32'hffff << (16 * r.a[1]) : '1;
    if (!r.w) cmp(rdata & am, IMG & am);
  endtask : run
  task automatic test_done();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    errors++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    width = steer_pkg::EXT_W8;
    rsel = 1'b1;
    pdyn = 1'b0;
    lat = 2'h0;
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    // second pass: slow far side on the dynamic path
    for (int p = 0; p < 2; p++) begin
      lat = 2'(2 * p);
      pdyn = p[0];
      foreach (ROWS[i]) run(ROWS[i]);
    end
    rsel = 1'b0;
    run(ROWS[15]);
    run(ROWS[4]);
    rsel = 1'b1;
    // reset in mid-split; held valid is ignored while busy
    req = '{1'b1, steer_pkg::SIZE_WORD, 2'h0, WD};
    width = steer_pkg::EXT_W8;
    req_valid = 1'b1;
    repeat (4) @(posedge mclk);
    #1 rst = 1'b1;
    req_valid = 1'b0;
    #1 cmp({req_ready, done, ext_strobe, lanes_n}, 7'h4f);
    cmp(ext_data, 32'h0);
    cmp({ext_write, ext_pdyn, ext_addr}, 4'h0);
    @(posedge mclk);
    #1 rst = 1'b0;
    run(ROWS[0]);
    test_done();
  end
endmodule : byte_lane_data_steering_test
